/* rtl/iopiw_pkg.sv */
// constants and types shared by the port, infrared and pwm logic
package iopiw_pkg;

	// pin organisation: four ports of four bits, index = port*4 + bit
	localparam int PORT_COUNT = 4;
	localparam int PORT_WIDTH = 4;
	localparam int PIN_COUNT  = PORT_COUNT * PORT_WIDTH;
	localparam int PORT_ONE   = 0;
	localparam int PORT_TWO   = 1;
	localparam int PORT_THREE = 2;
	localparam int PORT_SIX   = 3;
	localparam int IR_SOURCE_BIT    = PORT_THREE * PORT_WIDTH + 3;
	localparam int IR_DEFAULT_PIN   = PORT_THREE * PORT_WIDTH + 3;
	localparam int IR_ALTERNATE_PIN = PORT_TWO * PORT_WIDTH + 3;
	localparam int PWM_FIRST_PIN    = PORT_THREE * PORT_WIDTH;
	localparam int PWM_CHANNELS     = 4;
	localparam int PWM_DUTY_WIDTH   = 8;

	// register byte addresses
	localparam logic [7:0] ADDR_DATA_OUT = 8'h00;
	localparam logic [7:0] ADDR_DIR      = 8'h04;
	localparam logic [7:0] ADDR_PIN_IN   = 8'h08;
	localparam logic [7:0] ADDR_MODE     = 8'h0c;
	localparam logic [7:0] ADDR_MODE1    = 8'h10;
	localparam logic [7:0] ADDR_PWM_EN   = 8'h14;
	localparam logic [7:0] ADDR_DUTY0    = 8'h18;
	localparam logic [7:0] ADDR_CTRL     = 8'h28;

	// field positions
	localparam int MODE_IR_ENABLE_BIT   = 3;
	localparam int MODE1_IR_PIN_SEL_BIT = 1;
	localparam int CTRL_STOP_BIT        = 0;
	localparam int CTRL_WAKE_FLAG_BIT   = 1;

	// reset values
	localparam logic [15:0] RESET_DATA_OUT = 16'h0000;
	localparam logic [15:0] RESET_DIR      = 16'h0000;
	localparam logic [7:0]  RESET_DUTY     = 8'h00;

	// timing: carrier half period rounded down to whole clocks
	localparam int MCLK_HZ       = 10_000_000;
	localparam int IR_CARRIER_HZ = 38_500;
	localparam int IR_HALF_CYCLES = (MCLK_HZ / (2 * IR_CARRIER_HZ)) < 1 ? 1 :
		(MCLK_HZ / (2 * IR_CARRIER_HZ));
	localparam int PWM_STEP_DIV_DEFAULT = 4;

	// configuration carried from the register file to the pin logic
	typedef struct packed {
		logic                    irEnable;
		logic                    irPinSelect;
		logic [PWM_CHANNELS-1:0] pwmEnable;
	} iopiw_mode_s;

	typedef enum logic {
		PWR_RUN,
		PWR_STOPPED
	} iopiw_power_e;

endpackage

/* rtl/iopiw_pwm.sv */
// shared 256-step pwm timebase with one comparator per channel
`timescale 1ns/1ps
`default_nettype none
module iopiw_pwm
	import iopiw_pkg::*;
#(
	parameter int CHANNELS   = PWM_CHANNELS,
	parameter int DUTY_WIDTH = PWM_DUTY_WIDTH,
	parameter int STEP_DIV   = PWM_STEP_DIV_DEFAULT
) (
	input  wire logic                           mclk,
	input  wire logic                           arst_n,
	input  wire logic [CHANNELS*DUTY_WIDTH-1:0] duty,
	output var  logic [CHANNELS-1:0]            pwmOut
);

	// the divider is 16 bits, the comparator needs at least one bit
	if (STEP_DIV < 1 || STEP_DIV > 65535 || DUTY_WIDTH < 1 || CHANNELS < 1) begin : g_check
		$error("iopiw_pwm: unsupported parameter value");
	end

	localparam logic [15:0] DIV_LAST = 16'(STEP_DIV - 1);

	logic [15:0]           divCount;
	logic                  stepEn;
	logic [DUTY_WIDTH-1:0] stepCount;

	assign stepEn = (divCount == DIV_LAST);

	// step enable divider, one pulse every STEP_DIV clocks
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			divCount <= 16'h0000;
		end else begin
			divCount <= stepEn ? 16'h0000 : divCount + 16'h0001;
		end
	end

	// period counter wraps naturally after all steps
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stepCount <= '0;
		end else if (stepEn) begin
			stepCount <= stepCount + DUTY_WIDTH'(1);
		end
	end

	// high for duty steps of the period, constant low at zero
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				pwmOut[ch] <= 1'b0;
			end else begin
				pwmOut[ch] <= stepCount < duty[ch*DUTY_WIDTH +: DUTY_WIDTH];
			end
		end
	end

endmodule
`default_nettype wire

/* rtl/iopiw_top.sv */
// general purpose ports with stop-mode wake, infrared carrier and pwm
//
// Overview of operation
// - Four ports of four bits each give sixteen separately addressed pins.
// - Every pin is set on its own as an output or as an input with weak pull-down.
// - The stop command halts the system clock and puts the chip into its stopped state.
// - While stopped, any edge on any port pin restarts the system clock.
// - Bit 3 of the mode register turns the infrared modulation on and off.
// - With infrared on, the port three bit 3 data is modulated by a 38.5 kHz square wave.
// - The pin-select bit of mode register 1 sends the infrared to port two bit 3 when 1, else to port three bit 3.
// - Port three bits 0 to 3 can each output pwm from its own 8-bit duty register.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module iopiw_top
	import iopiw_pkg::*;
#(
	parameter int PWM_STEP_DIV = PWM_STEP_DIV_DEFAULT
) (
	input  wire logic                 mclk,
	input  wire logic                 arst_n,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output var  logic [31:0]          prdata,
	output var  logic                 pready,
	output var  logic                 pslverr,
	input  wire logic [PIN_COUNT-1:0] pinIn,
	output var  logic [PIN_COUNT-1:0] pinOut,
	output var  logic [PIN_COUNT-1:0] pinOe,
	output var  logic [PIN_COUNT-1:0] pinPullDown,
	output var  logic                 sysClkRun
);

	if (PWM_STEP_DIV < 1) begin : g_check
		$error("iopiw_top: PWM_STEP_DIV must be at least 1");
	end

	// the carrier counter is eight bits wide
	if (IR_HALF_CYCLES > 256) begin : g_ir_check
		$error("iopiw_top: carrier half period does not fit the counter");
	end

	localparam logic [7:0] IR_HALF_LAST = 8'(IR_HALF_CYCLES - 1);
	// edges count only once the three stages and the level hold real pin values
	localparam logic [2:0] SETTLE_LAST  = 3'h4;

	// register file state
	logic [PIN_COUNT-1:0]                   dataOut;
	logic [PIN_COUNT-1:0]                   dirOut;
	iopiw_mode_s                            mode;
	logic [PWM_CHANNELS*PWM_DUTY_WIDTH-1:0] duty;
	logic                                   wakeFlag;
	iopiw_power_e                           power;
	iopiw_power_e                           next_power;

	// pin input synchronisers and filtered levels
	logic [PIN_COUNT-1:0] syncA;
	logic [PIN_COUNT-1:0] syncB;
	logic [PIN_COUNT-1:0] syncC;
	logic [PIN_COUNT-1:0] pinLevel;
	logic [PIN_COUNT-1:0] next_pinLevel;
	logic [PIN_COUNT-1:0] pinAgree;
	logic                 pinEdge;
	logic [2:0]           settle;

	// infrared carrier and pwm
	logic [7:0]              carrierCount;
	logic                    carrier;
	logic                    irModulated;
	logic [PWM_CHANNELS-1:0] pwmOut;
	logic [PIN_COUNT-1:0]    next_pinOut;

	// bus decode
	logic        busSetup;
	logic        busDone;
	logic        wrDone;
	logic        addrMapped;
	logic        dutyHit;
	logic [1:0]  dutyIndex;
	logic [31:0] readMux;
	logic        stopRequest;
	logic        wakeClear;

	// three-stage sampling; first stage feeds only the second
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			syncA <= '0;
			syncB <= '0;
			syncC <= '0;
		end else begin
			syncA <= pinIn;
			syncB <= syncA;
			syncC <= syncB;
		end
	end

	// a level counts once the second and third stages agree
	assign pinAgree      = ~(syncB ^ syncC);
	assign next_pinLevel = (pinAgree & syncC) | (~pinAgree & pinLevel);

	// settle count after reset; without it the first load of the real pin levels
	// looks like an edge, at the cost of missing a pin change in those first clocks
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			settle <= 3'h0;
		end else if (settle != SETTLE_LAST) begin
			settle <= settle + 3'h1;
		end
	end

	// any accepted change on any of the sixteen pins is an edge
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pinLevel <= '0;
			pinEdge  <= 1'b0;
		end else begin
			pinLevel <= next_pinLevel;
			pinEdge  <= (settle == SETTLE_LAST) && |(next_pinLevel ^ pinLevel);
		end
	end

	// apb decode; access phase answered on its second cycle
	assign busSetup    = psel & penable & ~pready;
	assign busDone     = psel & penable & pready;
	assign wrDone      = busDone & pwrite & ~pslverr;
	assign dutyHit     = (paddr[7:4] == ADDR_DUTY0[7:4] && paddr[3:2] >= 2'b10) ||
		(paddr[7:2] == 6'(ADDR_DUTY0[7:2] + 6'h2)) ||
		(paddr[7:2] == 6'(ADDR_DUTY0[7:2] + 6'h3));
	assign dutyIndex   = 2'(paddr[7:2] - ADDR_DUTY0[7:2]);
	assign addrMapped  = (paddr[1:0] == 2'b00) && (paddr == ADDR_DATA_OUT ||
		paddr == ADDR_DIR || paddr == ADDR_PIN_IN || paddr == ADDR_MODE ||
		paddr == ADDR_MODE1 || paddr == ADDR_PWM_EN || paddr == ADDR_CTRL || dutyHit);
	assign stopRequest = wrDone && paddr == ADDR_CTRL && pwdata[CTRL_STOP_BIT];
	assign wakeClear   = wrDone && paddr == ADDR_CTRL && pwdata[CTRL_WAKE_FLAG_BIT];

	// read data selection, unused high bits read as zero
	always_comb begin
		readMux = 32'h0000_0000;
		if (dutyHit) begin
			readMux[PWM_DUTY_WIDTH-1:0] = duty[dutyIndex*PWM_DUTY_WIDTH +: PWM_DUTY_WIDTH];
		end else begin
			unique case (paddr)
				ADDR_DATA_OUT: readMux[PIN_COUNT-1:0] = dataOut;
				ADDR_DIR:      readMux[PIN_COUNT-1:0] = dirOut;
				ADDR_PIN_IN:   readMux[PIN_COUNT-1:0] = pinLevel;
				ADDR_MODE:     readMux[MODE_IR_ENABLE_BIT] = mode.irEnable;
				ADDR_MODE1:    readMux[MODE1_IR_PIN_SEL_BIT] = mode.irPinSelect;
				ADDR_PWM_EN:   readMux[PWM_CHANNELS-1:0] = mode.pwmEnable;
				ADDR_CTRL: begin
					readMux[CTRL_STOP_BIT]      = (power == PWR_STOPPED);
					readMux[CTRL_WAKE_FLAG_BIT] = wakeFlag;
				end
				default:       readMux = 32'h0000_0000;
			endcase
		end
	end

	// bus answer: ready and data raised together, ready dropped after one cycle, data held
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= busSetup;
			pslverr <= busSetup & ~addrMapped;
			if (busSetup) begin
				prdata <= (pwrite || !addrMapped) ? 32'h0000_0000 : readMux;   // refused reads give zero
			end
		end
	end

	// port data and direction
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			dataOut <= RESET_DATA_OUT;
			dirOut  <= RESET_DIR;
		end else if (wrDone && paddr == ADDR_DATA_OUT) begin
			dataOut <= pwdata[PIN_COUNT-1:0];
		end else if (wrDone && paddr == ADDR_DIR) begin
			dirOut <= pwdata[PIN_COUNT-1:0];
		end
	end

	// mode bits and pwm enables
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mode <= '0;
		end else if (wrDone && paddr == ADDR_MODE) begin
			mode.irEnable <= pwdata[MODE_IR_ENABLE_BIT];
		end else if (wrDone && paddr == ADDR_MODE1) begin
			mode.irPinSelect <= pwdata[MODE1_IR_PIN_SEL_BIT];
		end else if (wrDone && paddr == ADDR_PWM_EN) begin
			mode.pwmEnable <= pwdata[PWM_CHANNELS-1:0];
		end
	end

	// four independent duty registers
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			duty <= {PWM_CHANNELS{RESET_DUTY}};
		end else if (wrDone && dutyHit) begin
			duty[dutyIndex*PWM_DUTY_WIDTH +: PWM_DUTY_WIDTH] <= pwdata[PWM_DUTY_WIDTH-1:0];
		end
	end

	// power state: a wake edge wins over a stop written in the same cycle
	always_comb begin
		next_power = power;
		unique case (power)
			PWR_RUN: begin
				if (stopRequest && !pinEdge) begin
					next_power = PWR_STOPPED;
				end
			end
			PWR_STOPPED: begin
				if (pinEdge) begin
					next_power = PWR_RUN;
				end
			end
		endcase
	end

	// this logic stays on mclk; only the core clock is gated by sysClkRun
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			power     <= PWR_RUN;
			sysClkRun <= 1'b1;
		end else begin
			power     <= next_power;
			sysClkRun <= (next_power == PWR_RUN);
		end
	end

	// sticky wake flag, a new wake beats a clear in the same cycle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wakeFlag <= 1'b0;
		end else if (power == PWR_STOPPED && pinEdge) begin
			wakeFlag <= 1'b1;
		end else if (wakeClear) begin
			wakeFlag <= 1'b0;
		end
	end

	// carrier square wave, held low and reset while infrared is off
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			carrierCount <= 8'h00;
			carrier      <= 1'b0;
		end else if (!mode.irEnable) begin
			carrierCount <= 8'h00;
			carrier      <= 1'b0;
		end else if (carrierCount == IR_HALF_LAST) begin
			carrierCount <= 8'h00;
			carrier      <= ~carrier;
		end else begin
			carrierCount <= carrierCount + 8'h01;
		end
	end

	// modulated signal is low whenever the source data is low
	assign irModulated = dataOut[IR_SOURCE_BIT] & carrier;

	iopiw_pwm #(
		.CHANNELS   (PWM_CHANNELS),
		.DUTY_WIDTH (PWM_DUTY_WIDTH),
		.STEP_DIV   (PWM_STEP_DIV)
	) u_pwm (
		.mclk   (mclk),
		.arst_n (arst_n),
		.duty   (duty),
		.pwmOut (pwmOut)
	);

	// pin output selection: plain data, then pwm, then infrared routing
	always_comb begin
		next_pinOut = dataOut;
		for (int ch = 0; ch < PWM_CHANNELS; ch++) begin
			if (mode.pwmEnable[ch]) begin
				next_pinOut[PWM_FIRST_PIN + ch] = pwmOut[ch];
			end
		end
		if (mode.irEnable) begin
			if (mode.irPinSelect) begin
				next_pinOut[IR_ALTERNATE_PIN] = irModulated;
			end else begin
				next_pinOut[IR_DEFAULT_PIN] = irModulated;
			end
		end
	end

	// registered pin drive; enable and pull-down switch on the same edge so a pin
	// is never left both undriven and unpulled while its direction changes
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pinOut      <= '0;
			pinOe       <= '0;
			pinPullDown <= ~RESET_DIR;
		end else begin
			pinOut      <= next_pinOut;
			pinOe       <= dirOut;
			pinPullDown <= ~dirOut;
		end
	end

endmodule
`default_nettype wire

/* verification/iopiw_checker.sv */
// concurrent checks on bus timing, pull-downs, stop-wake and the default infrared pin
`timescale 1ns/1ps
`default_nettype none
module iopiw_checker
	import iopiw_pkg::*;
#(
	parameter int PWM_STEP_DIV = PWM_STEP_DIV_DEFAULT
) (
	input wire logic                 mclk,
	input wire logic                 arst_n,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [7:0]           paddr,
	input wire logic [31:0]          pwdata,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	input wire logic [PIN_COUNT-1:0] pinIn,
	input wire logic [PIN_COUNT-1:0] pinOut,
	input wire logic [PIN_COUNT-1:0] pinOe,
	input wire logic [PIN_COUNT-1:0] pinPullDown,
	input wire logic                 sysClkRun
);
	// write commit strobe and stop request, named once for reuse
	wire logic wrDone;
	wire logic stopWr;
	assign wrDone = psel && penable && pready && pwrite;
	assign stopWr = wrDone && paddr == ADDR_CTRL && pwdata[CTRL_STOP_BIT];

	// shadows of the infrared controls, only ports are visible here
	logic irOn;
	logic irSel;
	logic irData;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			irOn <= 1'b0;
			irSel <= 1'b0;
			irData <= 1'b0;
		end else if (wrDone) begin
			if (paddr == ADDR_MODE) irOn <= pwdata[MODE_IR_ENABLE_BIT];
			if (paddr == ADDR_MODE1) irSel <= pwdata[MODE1_IR_PIN_SEL_BIT];
			if (paddr == ADDR_DATA_OUT) irData <= pwdata[IR_SOURCE_BIT];
		end
	end

	// modes of the default infrared pin
	wire logic irDef;
	wire logic irLow;
	assign irDef = irOn && !irSel && irData;
	assign irLow = irOn && !irSel && !irData;

	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);

	pready_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("pready not after one wait cycle");
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	pull_excl_a: assert property ((pinOe ^ pinPullDown) == 16'hffff)
		else $error("pull-down and drive disagree");
	stop_halt_a: assert property (stopWr |=> !sysClkRun)
		else $error("clock still running after stop");
	halt_cause_a: assert property ($fell(sysClkRun) |-> $past(stopWr))
		else $error("clock stopped without request");
	wake_edge_a: assert property (!sysClkRun && $changed(pinIn) |-> ##[1:8] sysClkRun)
		else $error("pin edge did not wake");
	ir_low_a: assert property ($past(irLow) && irLow |-> !pinOut[IR_DEFAULT_PIN])
		else $error("infrared pin high with data low");
	ir_carrier_a: assert property ($past(irDef, 2) && $past(irDef) && irDef
		&& $changed(pinOut[IR_DEFAULT_PIN])
		|=> ($stable(pinOut[IR_DEFAULT_PIN]) || !irDef) [*8]) else $error("carrier too fast");
endmodule

bind iopiw_top iopiw_checker #(.PWM_STEP_DIV(PWM_STEP_DIV)) chk_u (
	.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pinPullDown(pinPullDown),
	.sysClkRun(sysClkRun)
);
`default_nettype wire

/* verification/iopiw_pins_model.sv */
// far side of the pins: keys or sensors, weak pull-downs, resolved level
`timescale 1ns/1ps
`default_nettype none
module iopiw_pins_model
	import iopiw_pkg::*;
(
	input  wire logic [PIN_COUNT-1:0] pinOut,
	input  wire logic [PIN_COUNT-1:0] pinOe,
	input  wire logic [PIN_COUNT-1:0] pinPullDown,
	input  wire logic [PIN_COUNT-1:0] extDrive,
	input  wire logic [PIN_COUNT-1:0] extLevel,
	output var  logic [PIN_COUNT-1:0] pinIn
);
	// device drive wins, then an outside driver, else the pull-down
	always_comb begin
		for (int i = 0; i < PIN_COUNT; i++) begin
			if (pinOe[i]) pinIn[i] = pinOut[i];
			else if (extDrive[i]) pinIn[i] = extLevel[i];
			else pinIn[i] = pinPullDown[i] ? 1'b0 : ~pinOut[i]; // floating: no stale value
		end
	end
endmodule
`default_nettype wire

/* verification/tb_io_port_ir_pwm_wake.sv */
// self-checking bench for ports, stop-wake, infrared carrier and pwm
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin n_fail++; \
	$display("CHECK FAILED %s exp %h got %h", nm, ex, gt); end end
module tb_io_port_ir_pwm_wake
	import iopiw_pkg::*;
;
	logic        mclk, arst_n, psel, penable, pwrite, pready, pslverr, errv, sysClkRun;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [15:0] pinIn, pinOut, pinOe, pinPullDown, extDrive, extLevel;
	int          n_fail, num_checks;

	// pwm steps every clock so one period is 256 clocks
	iopiw_top #(.PWM_STEP_DIV(1)) dut_u (.mclk(mclk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
		.pinPullDown(pinPullDown), .sysClkRun(sysClkRun));
	iopiw_pins_model pins_u (.pinOut(pinOut), .pinOe(pinOe), .pinPullDown(pinPullDown),
		.extDrive(extDrive), .extLevel(extLevel), .pinIn(pinIn));

	// 10 MHz clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// one bus transfer; held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
		apb(1'b0, a, 32'h0);
		`CHK(nm, ex, rdv)
	endtask
	// clocks between two changes of a pin, capped so a stuck pin ends it
	task automatic gap(input int idx, output int n);
		logic v;
		for (int k = 0; k < 2; k++) begin
			v = pinOut[idx];
			n = 0;
			while (pinOut[idx] === v && n < 400) begin
				@(posedge mclk);
				n++;
			end
		end
	endtask
	task automatic steady(input int idx, input logic v, input string nm);
		int bad;
		bad = 0;
		repeat (300) begin
			@(posedge mclk);
			bad += (pinOut[idx] !== v);
		end
		`CHK(nm, 0, bad)
	endtask

	task automatic t_regs();
		`CHK("oe rst", 16'h0, pinOe)
		`CHK("pull rst", 16'hffff, pinPullDown)
		`CHK("clk run", 1'b1, sysClkRun)
		rd(ADDR_DIR, 32'h0, "dir rst");
		rd(ADDR_DUTY0, 32'h0, "duty rst");
		`CHK("mapped ok", 1'b0, errv)
		wr(8'h40, 32'h1);
		`CHK("unmapped err", 1'b1, errv)
		rd(8'h19, 32'h0, "misaligned rd");
		`CHK("misaligned err", 1'b1, errv)
		$display("test regs done");
	endtask
	// one pin per port wakes the stopped chip, rising and falling
	task automatic t_stop();
		int n;
		for (int p = 0; p < PORT_COUNT; p++) begin
			wr(ADDR_CTRL, 32'h1);
			repeat (10) @(posedge mclk);
			`CHK("halted", 1'b0, sysClkRun)
			extLevel[p * 5] <= ~extLevel[p * 5];
			n = 0;
			while (sysClkRun !== 1'b1 && n < 20) begin
				@(posedge mclk);
				n++;
			end
			`CHK("woken", 1'b1, sysClkRun)
			rd(ADDR_CTRL, 32'h2, "wake flag");
			wr(ADDR_CTRL, 32'h2);
		end
		$display("test stop done");
	endtask
	task automatic t_dir();
		extDrive <= 16'ha000;
		extLevel <= 16'hffff;
		wr(ADDR_DATA_OUT, 32'hffff);
		wr(ADDR_DIR, 32'h5aa5);
		repeat (8) @(posedge mclk);
		`CHK("oe", 16'h5aa5, pinOe)
		`CHK("pull", 16'ha55a, pinPullDown)
		rd(ADDR_PIN_IN, 32'hfaa5, "levels");
		wr(ADDR_DIR, 32'h0);
		extDrive <= 16'h0;
		$display("test dir done");
	endtask
	task automatic t_ir();
		int n;
		wr(ADDR_DIR, 32'h0880);
		wr(ADDR_MODE, 32'h8);
		rd(ADDR_MODE, 32'h8, "mode rb");
		wr(ADDR_DATA_OUT, 32'h0800);
		gap(IR_DEFAULT_PIN, n);
		`CHK("half period", IR_HALF_CYCLES, n)
		wr(ADDR_DATA_OUT, 32'h0);
		repeat (4) @(posedge mclk);
		steady(IR_DEFAULT_PIN, 1'b0, "default low");
		wr(ADDR_DATA_OUT, 32'h0800);
		steady(IR_ALTERNATE_PIN, 1'b0, "alt idle");
		wr(ADDR_MODE1, 32'h2);
		gap(IR_ALTERNATE_PIN, n);
		`CHK("alt half", IR_HALF_CYCLES, n)
		steady(IR_DEFAULT_PIN, 1'b1, "default plain");
		wr(ADDR_DATA_OUT, 32'h0);
		repeat (4) @(posedge mclk);
		steady(IR_ALTERNATE_PIN, 1'b0, "data low");
		wr(ADDR_MODE, 32'h0);
		wr(ADDR_DATA_OUT, 32'h0880);
		repeat (4) @(posedge mclk);
		steady(IR_ALTERNATE_PIN, 1'b1, "ir off");
		$display("test ir done");
	endtask
	// four duties at once: quarter, zero, full scale, one step
	task automatic t_pwm();
		int hi [4];
		logic [7:0] dt [4];
		dt = '{8'h40, 8'h00, 8'hff, 8'h01};
		hi = '{0, 0, 0, 0};
		wr(ADDR_DIR, 32'h0f00);
		wr(ADDR_PWM_EN, 32'hf);
		for (int i = 0; i < 4; i++) wr(ADDR_DUTY0 + 8'(4 * i), {24'h0, dt[i]});
		repeat (300) @(posedge mclk);
		repeat (256) begin
			@(posedge mclk);
			for (int c = 0; c < 4; c++) hi[c] += int'(pinOut[PWM_FIRST_PIN + c] === 1'b1);
		end
		for (int c = 0; c < 4; c++) `CHK("pwm high", int'(dt[c]), hi[c])
		$display("test pwm done");
	endtask

	task automatic print_verdict();
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// watchdog, far beyond the few thousand clocks the tests take
	initial begin
		repeat (30000) @(posedge mclk);
		n_fail++;
		print_verdict();
	end

	initial begin
		arst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		extDrive = 16'h8421;
		extLevel = 16'h8020;
		n_fail = 0;
		num_checks = 0;
		repeat (8) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (10) @(posedge mclk);
		t_regs();
		t_stop();
		t_dir();
		t_ir();
		t_pwm();
		print_verdict();
	end
endmodule
`default_nettype wire
